/* File: bstp_pkg.sv */
// Behaviour
// R1 - instruction shift register is four bits long
// R2 - bypass path is one flip-flop from test input to test output
// R3 - identity register is 32 bits and shifts out when selected
// R4 - identity bits 31:28 hold the version field
// R5 - identity bits 27:12 hold the part number code
// R6 - identity bits 11:1 hold the maker code
// R7 - identity bit 0 is always one
// R8 - code 0000 selects pin chain and drives its cells onto outputs
// R9 - code 1111 selects the single-bit bypass path
// R10 - code 0010 loads identity value and selects identity register
// R11 - code 0100 selects bypass and floats every output except test output
// R12 - code 0011 drives chain cells onto outputs, bypass is shifted
// R13 - code 0001 selects chain and captures pin inputs and outputs
// R14 - code 0001 lets shifted data preload cells without disturbing pins
// R15 - controller issues only the six defined codes
// R16 - controller runs the test clock at one 12.5 MHz rate
// R17 - chain covers functional pins only, never the test pins
// R18 - standard sixteen-state controller stepped by mode select on rising edges
// R19 - test reset or five mode-high clocks reach reset with identity selected; after the five clocks identity loads on the next rising edge in reset
package bstp_pkg;
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int IN_W = 4;
    localparam int OUT_W = 4;
    localparam int CHAIN_W = IN_W + OUT_W;
    localparam int FIFO_DEPTH = 16;
    localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] INS_CLAMP = 4'h3;
    localparam logic [IR_W-1:0] INS_HIGHZ = 4'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    // identity field values are arbitrary
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'hA5C3;
    localparam logic [10:0] ID_MAKER = 11'h2B5;
    localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    typedef enum logic [15:0]
    {
        S_RESET = 16'h0001,
        S_IDLE = 16'h0002,
        S_SEL_DR = 16'h0004,
        S_CAP_DR = 16'h0008,
        S_SHIFT_DR = 16'h0010,
        S_EXIT1_DR = 16'h0020,
        S_PAUSE_DR = 16'h0040,
        S_EXIT2_DR = 16'h0080,
        S_UPD_DR = 16'h0100,
        S_SEL_IR = 16'h0200,
        S_CAP_IR = 16'h0400,
        S_SHIFT_IR = 16'h0800,
        S_EXIT1_IR = 16'h1000,
        S_PAUSE_IR = 16'h2000,
        S_EXIT2_IR = 16'h4000,
        S_UPD_IR = 16'h8000
    } bstp_tap_t;
    typedef struct packed {
        logic use_chain;
        logic use_id;
        logic drive;
        logic highz;
    } bstp_dec_t;
    function automatic bstp_dec_t bstp_decode(input logic [IR_W-1:0] ins);
        bstp_dec_t d;
        d = '0;
        case (ins)
            INS_EXTEST:
            begin
                d.use_chain = 1'b1; // R8
                d.drive = 1'b1; // R8
            end
            INS_SAMPLE: d.use_chain = 1'b1; // R13 R14
            INS_IDCODE: d.use_id = 1'b1; // R10
            INS_CLAMP: d.drive = 1'b1; // R12
            INS_HIGHZ: d.highz = 1'b1; // R11
            default: d = '0; // R9
        endcase
        return d;
    endfunction : bstp_decode
endpackage : bstp_pkg

/* File: bstp_top.sv */
`timescale 1ns/1ps
module bstp_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } bstp_fifo_t;
    bstp_fifo_t q;
    bstp_fifo_t n;
    logic push;
    logic pop;
    always_comb
    begin
        n = q;
        in_ready = (q.cnt != DEPTH[AW:0]);
        out_valid = (q.cnt != '0);
        out_data = q.mem[q.rp];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push)
        begin
            n.mem[q.wp] = in_data;
            n.wp = q.wp + 1'b1;
        end
        if (pop)
        begin
            n.rp = q.rp + 1'b1;
        end
        if (push && !pop)
        begin
            n.cnt = q.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            n.cnt = q.cnt - 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end
endmodule : bstp_fifo

module bstp_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    input wire logic [bstp_pkg::IN_W-1:0] pads_in,
    input wire logic [bstp_pkg::OUT_W-1:0] func_out,
    input wire logic [bstp_pkg::OUT_W-1:0] func_oe_n,
    input wire logic pin_hold,
    output logic [bstp_pkg::OUT_W-1:0] pad_out,
    output logic [bstp_pkg::OUT_W-1:0] pad_oe_n
);
    typedef struct packed {
        bstp_pkg::bstp_tap_t state;
        logic [bstp_pkg::IR_W-1:0] ir_shift;
        logic [bstp_pkg::IR_W-1:0] instr;
        logic byp;
        logic [bstp_pkg::ID_W-1:0] idsr;
        logic [bstp_pkg::CHAIN_W-1:0] chain;
        logic [bstp_pkg::CHAIN_W-1:0] pin_s1;
        logic [bstp_pkg::CHAIN_W-1:0] pin_s2;
        logic [bstp_pkg::OUT_W-1:0] upd_word;
        logic req_tgl;
        logic ack_s1;
        logic ack_s2;
    } bstp_tck_t;
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic pending;
        logic ack_tgl;
        logic drv_s1;
        logic drv_s2;
        logic hz_s1;
        logic hz_s2;
        logic [bstp_pkg::OUT_W-1:0] applied;
        logic [bstp_pkg::OUT_W-1:0] pad_out;
        logic [bstp_pkg::OUT_W-1:0] pad_oe_n;
    } bstp_clk_t;
    localparam bstp_tck_t TCK_RST = '{state: bstp_pkg::S_RESET, instr: bstp_pkg::INS_IDCODE, default: '0};
    localparam bstp_clk_t CLK_RST = '{pad_oe_n: '1, default: '0};

    bstp_tck_t t;
    bstp_tck_t next_t;
    bstp_clk_t c;
    bstp_clk_t next_c;
    bstp_pkg::bstp_dec_t dec;
    logic rst_s1;
    logic rst_n;
    logic busy;
    logic f_ready;
    logic f_valid;
    logic [bstp_pkg::OUT_W-1:0] f_data;
    logic next_tdo;
    logic next_tdo_oe_n;

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    always_comb
    begin
        next_t = t;
        dec = bstp_pkg::bstp_decode(t.instr);
        busy = t.req_tgl != t.ack_s2;
        // functional pins only; test pins never enter the chain
        next_t.pin_s1 = {pads_in, c.pad_out}; // R17
        next_t.pin_s2 = t.pin_s1;
        next_t.ack_s1 = c.ack_tgl;
        next_t.ack_s2 = t.ack_s1;
        case (t.state) // R18
            bstp_pkg::S_RESET: next_t.state = tms ? bstp_pkg::S_RESET : bstp_pkg::S_IDLE;
            bstp_pkg::S_IDLE: next_t.state = tms ? bstp_pkg::S_SEL_DR : bstp_pkg::S_IDLE;
            bstp_pkg::S_SEL_DR: next_t.state = tms ? bstp_pkg::S_SEL_IR : bstp_pkg::S_CAP_DR;
            bstp_pkg::S_CAP_DR: next_t.state = tms ? bstp_pkg::S_EXIT1_DR : bstp_pkg::S_SHIFT_DR;
            bstp_pkg::S_SHIFT_DR: next_t.state = tms ? bstp_pkg::S_EXIT1_DR : bstp_pkg::S_SHIFT_DR;
            bstp_pkg::S_EXIT1_DR: next_t.state = tms ? bstp_pkg::S_UPD_DR : bstp_pkg::S_PAUSE_DR;
            bstp_pkg::S_PAUSE_DR: next_t.state = tms ? bstp_pkg::S_EXIT2_DR : bstp_pkg::S_PAUSE_DR;
            bstp_pkg::S_EXIT2_DR: next_t.state = tms ? bstp_pkg::S_UPD_DR : bstp_pkg::S_SHIFT_DR;
            bstp_pkg::S_UPD_DR: next_t.state = tms ? bstp_pkg::S_SEL_DR : bstp_pkg::S_IDLE;
            bstp_pkg::S_SEL_IR: next_t.state = tms ? bstp_pkg::S_RESET : bstp_pkg::S_CAP_IR; // R19
            bstp_pkg::S_CAP_IR: next_t.state = tms ? bstp_pkg::S_EXIT1_IR : bstp_pkg::S_SHIFT_IR;
            bstp_pkg::S_SHIFT_IR: next_t.state = tms ? bstp_pkg::S_EXIT1_IR : bstp_pkg::S_SHIFT_IR;
            bstp_pkg::S_EXIT1_IR: next_t.state = tms ? bstp_pkg::S_UPD_IR : bstp_pkg::S_PAUSE_IR;
            bstp_pkg::S_PAUSE_IR: next_t.state = tms ? bstp_pkg::S_EXIT2_IR : bstp_pkg::S_PAUSE_IR;
            bstp_pkg::S_EXIT2_IR: next_t.state = tms ? bstp_pkg::S_UPD_IR : bstp_pkg::S_SHIFT_IR;
            bstp_pkg::S_UPD_IR: next_t.state = tms ? bstp_pkg::S_SEL_DR : bstp_pkg::S_IDLE;
            default: next_t.state = bstp_pkg::S_RESET;
        endcase
        case (t.state)
            bstp_pkg::S_RESET: next_t.instr = bstp_pkg::INS_IDCODE; // R19
            bstp_pkg::S_CAP_IR: next_t.ir_shift = bstp_pkg::IR_CAPTURE;
            bstp_pkg::S_SHIFT_IR: next_t.ir_shift = {tdi, t.ir_shift[bstp_pkg::IR_W-1:1]}; // R1
            bstp_pkg::S_UPD_IR: next_t.instr = t.ir_shift; // R1
            bstp_pkg::S_CAP_DR:
            begin
                next_t.byp = 1'b0;
                if (dec.use_chain)
                begin
                    next_t.chain = t.pin_s2; // R13
                end
                if (dec.use_id)
                begin
                    next_t.idsr = bstp_pkg::ID_VALUE; // R4 R5 R6 R7 R10
                end
            end
            bstp_pkg::S_SHIFT_DR:
            begin
                if (dec.use_chain)
                begin
                    next_t.chain = {tdi, t.chain[bstp_pkg::CHAIN_W-1:1]}; // R14
                end
                else if (dec.use_id)
                begin
                    next_t.idsr = {tdi, t.idsr[bstp_pkg::ID_W-1:1]}; // R3
                end
                else
                begin
                    next_t.byp = tdi; // R2 R9 R11 R12
                end
            end
            bstp_pkg::S_UPD_DR:
            begin
                // a word offered while the last is still crossing is dropped
                if (dec.use_chain && !busy)
                begin
                    next_t.upd_word = t.chain[bstp_pkg::OUT_W-1:0]; // R14
                    next_t.req_tgl = ~t.req_tgl;
                end
            end
            default: next_t.ir_shift = t.ir_shift;
        endcase
        next_tdo_oe_n = 1'b1;
        next_tdo = 1'b0;
        if (t.state == bstp_pkg::S_SHIFT_IR)
        begin
            next_tdo_oe_n = 1'b0;
            next_tdo = t.ir_shift[0];
        end
        else if (t.state == bstp_pkg::S_SHIFT_DR)
        begin
            next_tdo_oe_n = 1'b0;
            next_tdo = dec.use_chain ? t.chain[0] : (dec.use_id ? t.idsr[0] : t.byp); // R2 R3
        end
    end

    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            t <= TCK_RST; // R19
        end
        else
        begin
            t <= next_t;
        end
    end

    // test output changes on the falling edge so the controller samples it mid-period
    always_ff @(negedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end
        else
        begin
            tdo <= next_tdo;
            tdo_oe_n <= next_tdo_oe_n;
        end
    end

    always_comb
    begin
        next_c = c;
        next_c.req_s1 = t.req_tgl;
        next_c.req_s2 = c.req_s1;
        next_c.req_s3 = c.req_s2;
        next_c.drv_s1 = dec.drive;
        next_c.drv_s2 = c.drv_s1;
        next_c.hz_s1 = dec.highz;
        next_c.hz_s2 = c.hz_s1;
        // upd_word holds still until the ack returns, so it is read without its own sync
        if (c.pending && f_ready)
        begin
            next_c.pending = 1'b0;
            next_c.ack_tgl = ~c.ack_tgl;
        end
        // a new request in the same cycle as the push wins over the clear
        if (c.req_s2 != c.req_s3)
        begin
            next_c.pending = 1'b1;
        end
        if (f_valid && !pin_hold)
        begin
            next_c.applied = f_data;
        end
        if (c.hz_s2)
        begin
            next_c.pad_out = func_out;
            next_c.pad_oe_n = '1; // R11
        end
        else if (c.drv_s2)
        begin
            next_c.pad_out = c.applied; // R8 R12
            next_c.pad_oe_n = '0; // R8 R12
        end
        else
        begin
            next_c.pad_out = func_out; // R14
            next_c.pad_oe_n = func_oe_n; // R14
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c <= CLK_RST;
        end
        else
        begin
            c <= next_c;
        end
    end

    bstp_fifo #(
        .WIDTH(bstp_pkg::OUT_W),
        .DEPTH(bstp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(c.pending),
        .in_ready(f_ready),
        .in_data(t.upd_word),
        .out_valid(f_valid),
        .out_ready(!pin_hold),
        .out_data(f_data)
    );

    assign pad_out = c.pad_out;
    assign pad_oe_n = c.pad_oe_n;
endmodule : bstp_top

/* File: bstp_top_sva.sv */
`timescale 1ns/1ps
module bstp_top_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    input wire logic [bstp_pkg::IN_W-1:0] pads_in,
    input wire logic [bstp_pkg::OUT_W-1:0] func_out,
    input wire logic [bstp_pkg::OUT_W-1:0] func_oe_n,
    input wire logic pin_hold,
    input wire logic [bstp_pkg::OUT_W-1:0] pad_out,
    input wire logic [bstp_pkg::OUT_W-1:0] pad_oe_n
);
    sequence five_high;
        tms [*5];
    endsequence
    sequence quiet_four;
        tdo_oe_n [*4];
    endsequence
    reset_walk_a: assert property (@(posedge tck) disable iff (!trst_n) five_high |=> quiet_four)
        else $error("test output enabled too soon after reset walk");
    trst_quiet_a: assert property (@(posedge clk) disable iff (!arst_n) !trst_n |-> tdo_oe_n && !tdo)
        else $error("test output active during test reset");
    tdo_idle_a: assert property (@(posedge clk) disable iff (!arst_n) tdo_oe_n |-> !tdo)
        else $error("test output not low while released");
    tdo_edge_a: assert property (@(posedge clk) disable iff (!trst_n) $changed(tdo) |-> !tck)
        else $error("test output moved outside falling edge");
    oe_edge_a: assert property (@(posedge clk) disable iff (!trst_n) $changed(tdo_oe_n) |-> !tck)
        else $error("test output enable moved outside falling edge");
    oe_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
        pad_oe_n == '1 || pad_oe_n == '0 || pad_oe_n == $past(func_oe_n))
        else $error("pin enables neither forced nor following core");
    highz_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        pad_oe_n == '1 && $past(arst_n, 4) |-> pad_out == $past(func_out))
        else $error("floated pins stopped following core values");
    // bench keeps func_oe_n off zero so both-zero enables mean forced drive
    hold_stall_a: assert property (@(posedge clk) disable iff (!arst_n)
        $past(pin_hold) && $past(pad_oe_n) == '0 && pad_oe_n == '0 |-> $stable(pad_out))
        else $error("driven pins changed while hold was high");
endmodule : bstp_top_sva
bind bstp_top bstp_top_sva i_sva (.clk(clk), .arst_n(arst_n), .tck(tck), .trst_n(trst_n), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pads_in(pads_in), .func_out(func_out),
    .func_oe_n(func_oe_n), .pin_hold(pin_hold), .pad_out(pad_out), .pad_oe_n(pad_oe_n));

/* File: bstp_ctl_model.sv */
`timescale 1ns/1ps
module bstp_ctl_model (
    output logic tck,
    output logic trst_n,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial
    begin
        tck = 1'b0;
        // released until treset pulls it low, so the reset always sees a real falling edge
        trst_n = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // clock stands low between frames; 80 ns period
    task step(input logic m_v, input logic d_v, output logic q);
        tms = m_v;
        tdi = d_v;
        #40 tck = 1'b1;
        q = tdo;
        #40 tck = 1'b0;
    endtask : step
    // starts and ends in idle; tdi toggles when unused so a stale bit never looks valid
    task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        // odd gap keeps test clock edges drifting against the core clock
        #1.7;
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask : scan
    task reset5;
        logic q;
        repeat (5) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask : reset5
    task treset;
        logic q;
        trst_n = 1'b0;
        #100 trst_n = 1'b1;
        #40 step(1'b0, ~tdi, q);
    endtask : treset
endmodule : bstp_ctl_model

/* File: test_boundary_scan_test_port.sv */
`timescale 1ns/1ps
module test_boundary_scan_test_port;
    logic clk, arst_n, pin_hold, spin;
    logic [bstp_pkg::IN_W-1:0] pads_in;
    logic [bstp_pkg::OUT_W-1:0] func_out, func_oe_n, pad_out, pad_oe_n, held, last;
    wire logic tck, trst_n, tms, tdi, tdo, tdo_oe_n;
    logic [31:0] q, d;
    int failures, checks_done;
    logic [3:0] codes [3] = '{bstp_pkg::INS_BYPASS, bstp_pkg::INS_HIGHZ, bstp_pkg::INS_CLAMP};
    bstp_ctl_model m (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));
    bstp_top i_dut (.clk(clk), .arst_n(arst_n), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pads_in(pads_in), .func_out(func_out), .func_oe_n(func_oe_n),
        .pin_hold(pin_hold), .pad_out(pad_out), .pad_oe_n(pad_oe_n));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
        if (spin)
        begin
            func_out <= 4'($urandom);
            func_oe_n <= 4'($urandom_range(15, 1));
        end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%0h expected=%0h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    function automatic logic [31:0] id_exp();
        return {bstp_pkg::ID_VERSION, bstp_pkg::ID_PART, bstp_pkg::ID_MAKER, 1'b1};
    endfunction : id_exp
    function automatic logic [31:0] byp_exp(input logic [31:0] din, input int n);
        return {din[30:0], 1'b0} & ((32'h1 << n) - 32'h1);
    endfunction : byp_exp
    // mode 0 normal, 1 floated, 2 forced drive of v
    task pins(input int mode, input logic [bstp_pkg::OUT_W-1:0] v);
        spin <= 1'b0;
        repeat (20) @(posedge clk);
        chk(32'(pad_oe_n), mode == 0 ? 32'(func_oe_n) : (mode == 1 ? 32'hF : 32'h0));
        chk(32'(pad_out), mode == 2 ? 32'(v) : 32'(func_out));
        spin <= 1'b1;
    endtask : pins
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        results();
    end
    initial
    begin
        arst_n = 1'b0;
        pin_hold = 1'b0;
        spin = 1'b1;
        pads_in = '0;
        func_out = '0;
        func_oe_n = 4'hF;
        void'($urandom(78));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        m.treset();
        m.scan(1'b0, 32, $urandom, q);
        chk(q, id_exp());
        d = $urandom;
        m.scan(1'b1, 8, {24'h0, bstp_pkg::INS_BYPASS, d[3:0]}, q);
        chk(q, {24'h0, d[3:0], bstp_pkg::IR_CAPTURE});
        $display("test idcode and instruction length done");
        foreach (codes[i])
        begin
            m.scan(1'b1, 4, {28'h0, codes[i]}, q);
            d = $urandom;
            m.scan(1'b0, 8, d, q);
            chk(q, byp_exp(d, 8));
            if (codes[i] == bstp_pkg::INS_HIGHZ) pins(1, '0);
        end
        m.reset5();
        m.scan(1'b0, 32, $urandom, q);
        chk(q, id_exp());
        $display("test bypass paths and reset walk done");
        @(posedge clk) pads_in <= 4'($urandom);
        m.scan(1'b1, 4, {28'h0, bstp_pkg::INS_SAMPLE}, q);
        m.scan(1'b0, 8, $urandom, q);
        chk(q[7:4], 32'(pads_in));
        pins(0, '0);
        m.scan(1'b1, 4, {28'h0, bstp_pkg::INS_EXTEST}, q);
        d = $urandom;
        m.scan(1'b0, 8, d, q);
        pins(2, d[3:0]);
        m.scan(1'b1, 4, {28'h0, bstp_pkg::INS_CLAMP}, q);
        pins(2, d[3:0]);
        $display("test sample, drive and clamp done");
        held = d[3:0];
        m.scan(1'b1, 4, {28'h0, bstp_pkg::INS_EXTEST}, q);
        @(posedge clk) pin_hold <= 1'b1;
        repeat (bstp_pkg::FIFO_DEPTH)
        begin
            d = $urandom;
            m.scan(1'b0, 8, d, q);
            last = d[3:0];
        end
        pins(2, held);
        @(posedge clk) pin_hold <= 1'b0;
        pins(2, last);
        $display("test held update queue done");
        m.scan(1'b1, 4, {28'h0, bstp_pkg::INS_BYPASS}, q);
        m.treset();
        chk(32'(tdo_oe_n), 32'h1);
        m.scan(1'b0, 32, $urandom, q);
        chk(q, id_exp());
        $display("test test reset done");
        results();
    end
endmodule : test_boundary_scan_test_port
